/* rtl/swmg_pkg.sv */
package swmg_pkg;
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int NORMAL_WINDOW_TIME_MS = 40;
   localparam int REF_CAP_NF = 47;
   localparam int LONG_WINDOW_FACTOR = 10;
   localparam int FAIL_PULSE_TIME_MS = 16;
   localparam int MIN_SERVICE_HIGH_TIME_US = 50;
   localparam int MIN_SERVICE_LOW_TIME_MAX_US = 10;
   localparam int LATCH_FAIL_LIMIT = 4;
   // Tick period assumed at the reference capacitor: 1 tick per 100 us
   localparam int TICK_PERIOD_US = 100;
   localparam int NORMAL_WINDOW_TICKS = NORMAL_WINDOW_TIME_MS * 1000 / TICK_PERIOD_US;
   localparam int LONG_WINDOW_TICKS = NORMAL_WINDOW_TICKS * LONG_WINDOW_FACTOR;
   localparam int FAIL_PULSE_CYCLES = FAIL_PULSE_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int MIN_HIGH_CYCLES = (MIN_SERVICE_HIGH_TIME_US * (CLK_FREQ_HZ / 1_000_000));
   localparam int WIN_W = 16;
   localparam int CNT_W = 24;
   localparam int FC_W = 3;
   typedef enum logic [2:0] {
      MODE_OFF, MODE_ACTIVE, MODE_FLASH, MODE_LOWPWR, MODE_SAFE, MODE_LATCH
   } swmg_mode_t;
endpackage

/* rtl/swmg_service_detect.sv */
`timescale 1ns/10ps
`default_nettype none
module swmg_service_detect
   import swmg_pkg::*;
#(
   parameter int MIN_HIGH = MIN_HIGH_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic serviceInput,
   output logic validToggle
);
   logic syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
   logic armed_ff, nxt_armed;
   logic [CNT_W-1:0] highCnt_ff, nxt_highCnt;
   always_comb begin
      nxt_syncA = serviceInput;
      nxt_syncB = syncA_ff;
      nxt_armed = armed_ff;
      nxt_highCnt = highCnt_ff;
      validToggle = 1'b0;
      if (!syncB_ff) begin
         nxt_armed = 1'b1;
         nxt_highCnt = '0;
      end else if (armed_ff) begin
         // Short high pulses never reach the threshold and are dropped
         if (highCnt_ff == CNT_W'(MIN_HIGH - 1)) begin
            validToggle = 1'b1;
            nxt_armed = 1'b0;
         end else begin
            nxt_highCnt = highCnt_ff + CNT_W'(1);
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncA_ff <= 1'b0;
         syncB_ff <= 1'b0;
         armed_ff <= 1'b0;
         highCnt_ff <= '0;
      end else begin
         syncA_ff <= nxt_syncA;
         syncB_ff <= nxt_syncB;
         armed_ff <= nxt_armed;
         highCnt_ff <= nxt_highCnt;
      end
   end
endmodule // swmg_service_detect
`default_nettype wire

/* rtl/swmg_top.sv */
`timescale 1ns/10ps
`default_nettype none
module swmg_top
   import swmg_pkg::*;
#(
   parameter int NORMAL_TICKS = NORMAL_WINDOW_TICKS,
   parameter int LONG_TICKS = LONG_WINDOW_TICKS,
   parameter int FAIL_CYCLES = FAIL_PULSE_CYCLES,
   parameter int MIN_HIGH = MIN_HIGH_CYCLES,
   parameter int FAIL_LIMIT = LATCH_FAIL_LIMIT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic serviceInput,
   input wire logic timebaseTick,
   input wire logic timingPinFixed,
   input wire logic flashIndication,
   input wire logic wakeRequest,
   input wire logic standbyRequest,
   input wire logic regResetsReleased,
   input wire logic overTempShutdown,
   input wire logic supplyOvervoltage,
   input wire logic supplyUndervoltage,
   input wire logic pumpUndervoltage,
   input wire logic persistentFault,
   output logic failOutputN_o,
   output logic failOutputN_oe_n,
   output logic outputsEnabled,
   output logic monitoringEnabled,
   output logic supervisorEnable,
   output logic failEvent,
   output logic serviceFlag,
   output swmg_mode_t mode,
   output logic [FC_W-1:0] consecutiveFailCounter
);
   // Two-flop synchronisers for pin level inputs
   logic [10:0] pinA_ff, pinB_ff, nxt_pinA, nxt_pinB;
   logic tickS, fixedS, flashS, wakeS, stbyS, relS, otS, ovS, uvS, cpS, persS;
   assign {tickS, fixedS, flashS, wakeS, stbyS, relS, otS, ovS, uvS, cpS, persS} = pinB_ff;
   always_comb begin
      nxt_pinA = {timebaseTick, timingPinFixed, flashIndication, wakeRequest,
                  standbyRequest, regResetsReleased, overTempShutdown,
                  supplyOvervoltage, supplyUndervoltage, pumpUndervoltage, persistentFault};
      nxt_pinB = pinA_ff;
   end
   logic tickD_ff, nxt_tickD;
   logic tickPulse;
   assign tickPulse = tickS & ~tickD_ff;
   logic validToggle;
   swmg_service_detect #(.MIN_HIGH(MIN_HIGH)) u_detect (
      .clk(clk),
      .rst(rst),
      .serviceInput(serviceInput),
      .validToggle(validToggle)
   );
   swmg_mode_t mode_ff, nxt_mode;
   logic wdOn_ff, nxt_wdOn;
   logic longWin_ff, nxt_longWin;
   logic flag_ff, nxt_flag;
   logic [WIN_W-1:0] winCnt_ff, nxt_winCnt;
   logic [CNT_W-1:0] pulseCnt_ff, nxt_pulseCnt;
   logic pulse_ff, nxt_pulse;
   logic [FC_W-1:0] fc_ff, nxt_fc;
   logic fail_ff, nxt_fail;
   logic wdRun, failNow, okNow;
   always_comb begin
      // Mode sequencing
      nxt_mode = mode_ff;
      unique case (mode_ff)
         MODE_OFF: if (wakeS) nxt_mode = MODE_ACTIVE;
         MODE_ACTIVE, MODE_FLASH, MODE_LOWPWR: begin
            if (!wakeS) nxt_mode = MODE_OFF;
            else if (persS || fc_ff >= FC_W'(FAIL_LIMIT)) nxt_mode = MODE_LATCH;
            else if (otS || ovS || uvS || cpS) nxt_mode = MODE_SAFE;
            else if (flashS) nxt_mode = MODE_FLASH;
            else if (stbyS) nxt_mode = MODE_LOWPWR;
            else nxt_mode = MODE_ACTIVE;
         end
         MODE_SAFE: begin
            if (!wakeS) nxt_mode = MODE_OFF;
            else if (persS) nxt_mode = MODE_LATCH;
            else if (!(otS || ovS || uvS || cpS)) nxt_mode = MODE_ACTIVE;
         end
         MODE_LATCH: if (!wakeS) nxt_mode = MODE_OFF;
         default: nxt_mode = MODE_OFF;
      endcase
   end
   always_comb begin
      // Watchdog runs only in ACTIVE with released resets
      wdRun = (mode_ff == MODE_ACTIVE) && relS;
      nxt_wdOn = wdRun;
      nxt_longWin = longWin_ff;
      nxt_flag = flag_ff;
      nxt_winCnt = winCnt_ff;
      failNow = 1'b0;
      okNow = 1'b0;
      if (!wdRun) begin
         nxt_longWin = 1'b1;
         nxt_flag = 1'b0;
         nxt_winCnt = '0;
      end else if (!wdOn_ff) begin
         nxt_longWin = 1'b1;
         nxt_flag = 1'b0;
         nxt_winCnt = '0;
      end else begin
         if (validToggle) nxt_flag = 1'b1;
         // A frozen timing pin stops the window but not the regulators
         if (tickPulse && !fixedS) begin
            if (winCnt_ff == WIN_W'((longWin_ff ? LONG_TICKS : NORMAL_TICKS) - 1)) begin
               nxt_winCnt = '0;
               nxt_longWin = 1'b0;
               if (flag_ff || validToggle) begin
                  okNow = 1'b1;
                  nxt_flag = 1'b0;
               end else begin
                  failNow = 1'b1;
               end
            end else begin
               nxt_winCnt = winCnt_ff + WIN_W'(1);
            end
         end
      end
   end
   always_comb begin
      nxt_tickD = tickS;
      nxt_fail = failNow;
      nxt_fc = fc_ff;
      if (mode_ff == MODE_OFF || mode_ff == MODE_FLASH || mode_ff == MODE_LOWPWR || okNow)
         nxt_fc = '0;
      else if (failNow && fc_ff < FC_W'(FAIL_LIMIT))
         nxt_fc = fc_ff + FC_W'(1);
      nxt_pulse = pulse_ff;
      nxt_pulseCnt = pulseCnt_ff;
      if (failNow) begin
         nxt_pulse = 1'b1;
         nxt_pulseCnt = '0;
      end else if (pulse_ff) begin
         if (pulseCnt_ff == CNT_W'(FAIL_CYCLES - 1)) nxt_pulse = 1'b0;
         else nxt_pulseCnt = pulseCnt_ff + CNT_W'(1);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinA_ff <= '0;
         pinB_ff <= '0;
         tickD_ff <= 1'b0;
         mode_ff <= MODE_OFF;
         wdOn_ff <= 1'b0;
         longWin_ff <= 1'b1;
         flag_ff <= 1'b0;
         winCnt_ff <= '0;
         pulseCnt_ff <= '0;
         pulse_ff <= 1'b0;
         fc_ff <= '0;
         fail_ff <= 1'b0;
      end else begin
         pinA_ff <= nxt_pinA;
         pinB_ff <= nxt_pinB;
         tickD_ff <= nxt_tickD;
         mode_ff <= nxt_mode;
         wdOn_ff <= nxt_wdOn;
         longWin_ff <= nxt_longWin;
         flag_ff <= nxt_flag;
         winCnt_ff <= nxt_winCnt;
         pulseCnt_ff <= nxt_pulseCnt;
         pulse_ff <= nxt_pulse;
         fc_ff <= nxt_fc;
         fail_ff <= nxt_fail;
      end
   end
   // Open drain: output data always low, enable low means pulling the pin low
   assign failOutputN_o = 1'b0;
   assign failOutputN_oe_n = ~(pulse_ff || mode_ff == MODE_LATCH);
   assign outputsEnabled = (mode_ff == MODE_ACTIVE) || (mode_ff == MODE_FLASH)
                           || (mode_ff == MODE_LOWPWR);
   assign monitoringEnabled = (mode_ff != MODE_OFF) && (mode_ff != MODE_LATCH)
                              && (mode_ff != MODE_LOWPWR);
   assign supervisorEnable = wdOn_ff;
   assign failEvent = fail_ff;
   assign serviceFlag = flag_ff;
   assign mode = mode_ff;
   assign consecutiveFailCounter = fc_ff;
endmodule // swmg_top
`default_nettype wire

/* test/swmg_props.sv */
`timescale 1ns/10ps
`default_nettype none
module swmg_props
   import swmg_pkg::*;
#(
   parameter int FAIL_CYCLES = FAIL_PULSE_CYCLES,
   parameter int FAIL_LIMIT = LATCH_FAIL_LIMIT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic failOutputN_oe_n,
   input wire logic outputsEnabled,
   input wire logic monitoringEnabled,
   input wire logic supervisorEnable,
   input wire logic failEvent,
   input wire swmg_mode_t mode,
   input wire logic [FC_W-1:0] consecutiveFailCounter
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [CNT_W-1:0] lowCnt_ff;
   // Measured at release, so a retriggered pulse may only be longer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lowCnt_ff <= '0;
      end else if (failOutputN_oe_n) begin
         lowCnt_ff <= '0;
      end else if (lowCnt_ff != '1) begin
         // Saturates so a long latch cannot wrap into a short count
         lowCnt_ff <= lowCnt_ff + CNT_W'(1);
      end
   end
   fail_drive_a: assert property (failEvent |=> !failOutputN_oe_n)
      else $error("fail pin not driven");
   // Leaving LATCH through OFF may release the pin at any time
   pulse_len_a: assert property ($rose(failOutputN_oe_n) && $past(mode) != MODE_LATCH
      |-> lowCnt_ff >= FAIL_CYCLES) else $error("fail pulse too short");
   latch_pin_a: assert property (mode == MODE_LATCH && $past(mode) == MODE_LATCH
      |-> !failOutputN_oe_n) else $error("fail pin released in latch");
   latch_entry_a: assert property ($rose(consecutiveFailCounter == FAIL_LIMIT)
      |=> mode == MODE_LATCH) else $error("no latch at limit");
   count_step_a: assert property (consecutiveFailCounter > $past(consecutiveFailCounter)
      |-> (failEvent || $past(failEvent))
      && consecutiveFailCounter == $past(consecutiveFailCounter) + 3'h1)
      else $error("bad counter step");
   wd_off_a: assert property (mode != MODE_ACTIVE |=> !supervisorEnable)
      else $error("watchdog on outside active");
   count_clear_a: assert property (mode inside {MODE_OFF, MODE_FLASH, MODE_LOWPWR}
      |=> consecutiveFailCounter == 3'h0) else $error("counter not cleared");
   safe_out_a: assert property (mode == MODE_SAFE |-> !outputsEnabled && monitoringEnabled)
      else $error("safe outputs wrong");
   latch_out_a: assert property (mode == MODE_LATCH |-> !outputsEnabled && !monitoringEnabled)
      else $error("latch outputs wrong");
endmodule // swmg_props
`default_nettype wire

/* test/swmg_mcu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module swmg_mcu_model (
   input wire logic clk,
   output logic serviceInput
);
   initial serviceInput = 1'b0;
   // Always starts low, so each rise follows a legal low phase
   task automatic serve(input int highCycles);
      repeat (4) @(negedge clk);
      serviceInput = 1'b1;
      repeat (highCycles) @(negedge clk);
      serviceInput = 1'b0;
   endtask
endmodule // swmg_mcu_model
`default_nettype wire

/* test/test_supply_watchdog_mode_gate.sv */
`timescale 1ns/10ps
`default_nettype none
module test_supply_watchdog_mode_gate;
   import swmg_pkg::*;
   localparam int NT = 4;
   localparam int LT = 40;
   localparam int FC = 50;
   localparam int MH = 5;
   logic clk = 1'b0, rst = 1'b1, tick = 1'b0, frozen = 1'b0, flash = 1'b0, wake = 1'b0;
   logic standby_request = 1'b0, rel = 1'b0, pers = 1'b0, pinO, oeN, outEn, monEn, wdOn, failEv, flag;
   logic [3:0] safeCause = 4'h0;
   logic serviceInput;
   swmg_mode_t mode;
   logic [FC_W-1:0] cnt;
   int mismatches = 0, n_checks = 0, nFail = 0, expCnt = 0, h, f0;
   logic [31:0] seed = 32'h8583C1C1;
   always #5 clk = ~clk;
   always @(posedge clk) if (failEv === 1'b1) nFail <= nFail + 1;
   swmg_mcu_model u_swmg_mcu_model (.clk(clk), .serviceInput(serviceInput));
   swmg_top #(.NORMAL_TICKS(NT), .LONG_TICKS(LT), .FAIL_CYCLES(FC), .MIN_HIGH(MH)) u_swmg_top (
      .clk(clk), .rst(rst), .serviceInput(serviceInput), .timebaseTick(tick),
      .timingPinFixed(frozen), .flashIndication(flash), .wakeRequest(wake),
      .standbyRequest(standby_request), .regResetsReleased(rel), .overTempShutdown(safeCause[0]),
      .supplyOvervoltage(safeCause[1]), .supplyUndervoltage(safeCause[2]),
      .pumpUndervoltage(safeCause[3]), .persistentFault(pers), .failOutputN_o(pinO),
      .failOutputN_oe_n(oeN), .outputsEnabled(outEn), .monitoringEnabled(monEn),
      .supervisorEnable(wdOn), .failEvent(failEv), .serviceFlag(flag), .mode(mode),
      .consecutiveFailCounter(cnt));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wait_mode(input swmg_mode_t m);
      for (int i = 0; i < 20 && mode !== m; i++) @(negedge clk);
      chk("mode", m, mode);
      if (mode !== m) close_out();
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         tick = 1'b1;
         repeat (3) @(negedge clk);
         tick = 1'b0;
         repeat (4) @(negedge clk);
      end
      f0 = nFail - f0;
   endtask
   // A window with one pulse of hi cycles; a frozen window must not end
   task automatic window(input int hi, input logic frz);
      frozen = frz;
      if (hi > 0) u_swmg_mcu_model.serve(hi);
      repeat (4) @(negedge clk);
      chk("flag", 3'(hi > MH + 1), {2'b00, flag});
      f0 = nFail;
      ticks(NT);
      if (!frz) expCnt = (hi > MH + 1) ? 0 : expCnt + 1;
      chk("failures", 3'(!frz && hi <= MH + 1), 3'(f0));
      if (f0 != 0) chk("pin", 3'h0, {2'b00, oeN});
      if (expCnt < 4) chk("count", 3'(expCnt), cnt);
   endtask
   initial begin
      #300000;
      mismatches++;
      close_out();
   end
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      wake = 1'b1;
      rel = 1'b1;
      wait_mode(MODE_ACTIVE);
      repeat (3) @(negedge clk);
      u_swmg_mcu_model.serve(MH - 2);
      u_swmg_mcu_model.serve(MH + 3);
      u_swmg_mcu_model.serve(MH + 6);
      f0 = nFail;
      ticks(LT - 1);
      chk("flag", 3'h1, {2'b00, flag});
      f0 = nFail;
      ticks(1);
      chk("failures", 3'h0, 3'(f0));
      chk("flag", 3'h0, {2'b00, flag});
      for (int w = 0; w < 8; w++) begin
         seed = xs(seed);
         h = (seed[1:0] == 2'h0) ? MH - 2 : MH + 2 + int'(seed[4:2]);
         window((expCnt == 2) ? MH + 2 : h, 1'b0);
      end
      window(0, 1'b1);
      window(MH + 2, 1'b0);
      repeat (4) window(0, 1'b0);
      wait_mode(MODE_LATCH);
      repeat (FC + 10) @(negedge clk);
      chk("pin", 3'h0, {2'b00, oeN});
      chk("pinData", 3'h0, {2'b00, pinO});
      wake = 1'b0;
      wait_mode(MODE_OFF);
      repeat (2) @(negedge clk);
      chk("count", 3'h0, cnt);
      wake = 1'b1;
      wait_mode(MODE_ACTIVE);
      for (int i = 0; i < 10 && wdOn !== 1'b1; i++) @(negedge clk);
      chk("enable", 3'h1, {2'b00, wdOn});
      f0 = nFail;
      ticks(LT - 1);
      chk("failures", 3'h0, 3'(f0));
      f0 = nFail;
      ticks(1);
      chk("failures", 3'h1, 3'(f0));
      repeat (FC + 10) @(negedge clk);
      chk("pin", 3'h1, {2'b00, oeN});
      flash = 1'b1;
      wait_mode(MODE_FLASH);
      flash = 1'b0;
      wait_mode(MODE_ACTIVE);
      standby_request = 1'b1;
      wait_mode(MODE_LOWPWR);
      standby_request = 1'b0;
      wait_mode(MODE_ACTIVE);
      repeat (3) @(negedge clk);
      chk("enable", 3'h1, {2'b00, wdOn});
      for (int k = 0; k < 4; k++) begin
         safeCause = 4'h1 << k;
         wait_mode(MODE_SAFE);
         safeCause = 4'h0;
         wait_mode(MODE_ACTIVE);
      end
      pers = 1'b1;
      wait_mode(MODE_LATCH);
      pers = 1'b0;
      wake = 1'b0;
      wait_mode(MODE_OFF);
      wake = 1'b1;
      wait_mode(MODE_ACTIVE);
      safeCause = 4'h8;
      wait_mode(MODE_SAFE);
      pers = 1'b1;
      wait_mode(MODE_LATCH);
      chk("pin", 3'h0, {2'b00, oeN});
      pers = 1'b0;
      safeCause = 4'h0;
      wake = 1'b0;
      wait_mode(MODE_OFF);
      close_out();
   end
endmodule // test_supply_watchdog_mode_gate
bind swmg_top swmg_props #(.FAIL_CYCLES(FAIL_CYCLES), .FAIL_LIMIT(FAIL_LIMIT)) u_swmg_props (
   .clk(clk), .rst(rst), .failOutputN_oe_n(failOutputN_oe_n), .outputsEnabled(outputsEnabled),
   .monitoringEnabled(monitoringEnabled), .supervisorEnable(supervisorEnable),
   .failEvent(failEvent), .mode(mode), .consecutiveFailCounter(consecutiveFailCounter));
`default_nettype wire
